//--- design/ais_pkg.sv
// Package of constants and types for the analog input scaler.
`default_nettype none
package ais_pkg;
	localparam int AIS_CH_NUM = 2;
	localparam logic [7:0] AIS_CH_COUNT = 8'h02;
	localparam int AIS_RAW_W = 10;
	// Object dictionary indices and subindices.
	localparam logic [15:0] AIS_IDX_VALUE = 16'h3320;
	localparam logic [15:0] AIS_IDX_OFFSET = 16'h3321;
	localparam logic [15:0] AIS_IDX_DIVISOR = 16'h3322;
	localparam logic [7:0] AIS_SUB_COUNT = 8'h00;
	localparam logic [7:0] AIS_SUB_CH1 = 8'h01;
	localparam logic [7:0] AIS_SUB_CH2 = 8'h02;
	// Values after reset.
	localparam logic [31:0] AIS_VALUE_RST = 32'h00000000;
	localparam logic [31:0] AIS_OFFSET_RST = 32'h00000000;
	localparam logic [31:0] AIS_DIVISOR_RST = 32'h00000001;
	// Physical conversion: zero point, full scale and 20 V or 20 mA over 1024 digits.
	localparam logic signed [11:0] AIS_VOLT_ZERO = 12'sh200;
	localparam int AIS_FULL_SCALE = 1024;
	localparam int AIS_SPAN_MILLI = 20000;
	localparam logic [9:0] AIS_PHYS_MUL = 10'(AIS_SPAN_MILLI / 32);
	localparam int AIS_PHYS_SHIFT = $clog2(AIS_FULL_SCALE / 32);
	// Divider timing: one quotient bit per cycle over a 33-bit dividend.
	localparam int AIS_DIV_BITS = 33;
	localparam logic [5:0] AIS_DIV_LAST = 6'(AIS_DIV_BITS - 1);
	localparam logic signed [32:0] AIS_POS_MAX = 33'sh07FFFFFFF;
	localparam logic signed [32:0] AIS_NEG_MIN = -33'sh080000000;
	typedef enum logic [1:0] {AIS_LOAD, AIS_DIV, AIS_DONE} ais_state_e;
endpackage
`default_nettype wire

//--- design/ais_scaler.sv
// Two-channel analog input scaler with object dictionary access.
// Summary of operation
// R1 - Each input reports (raw sample plus offset) divided by its divisor.
// R2 - Two channels; each group reports count 2 at subindex 0, read only.
// R3 - Configuring side never writes a zero divisor; such writes are refused.
// R4 - With offset 0 and divisor 1 the value is the raw count.
// R5 - Voltage reading is (raw minus 512) times 20 V over 1024 counts.
// R6 - Current reading is raw times 20 mA over 1024 counts.
// R7 - Scaled values update continuously, are read only, and feed process data.
// R8 - Each input has its own signed offset, reset to zero, read-write.
// R9 - Each input has its own signed divisor, reset to one, read-write.
// R10 - Division truncates toward zero; the sum is formed without overflow.
`default_nettype none
module ais_scaler
	import ais_pkg::*;
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic sys_rst,
	// Converter samples.
	input wire logic [AIS_RAW_W-1:0] adc_raw_ch1,
	input wire logic [AIS_RAW_W-1:0] adc_raw_ch2,
	input wire logic [AIS_CH_NUM-1:0] adc_valid,
	input wire logic [AIS_CH_NUM-1:0] ch_is_current,
	// Object dictionary access.
	input wire logic [15:0] od_index,
	input wire logic [7:0] od_sub,
	input wire logic od_wr,
	input wire logic od_rd,
	input wire logic [31:0] od_wdata,
	output logic [31:0] od_rdata,
	output logic od_ack,
	output logic od_err,
	// Process data.
	output logic [31:0] pd_value_ch1,
	output logic [31:0] pd_value_ch2,
	output logic [31:0] phys_milli_ch1,
	output logic [31:0] phys_milli_ch2,
	output logic pd_update
);
	logic [AIS_RAW_W-1:0] raw_q [AIS_CH_NUM];
	logic [31:0] offset_q [AIS_CH_NUM];
	logic [31:0] divisor_q [AIS_CH_NUM];
	logic [31:0] value_q [AIS_CH_NUM];
	logic [31:0] phys_q [AIS_CH_NUM];
	logic [AIS_RAW_W-1:0] adc_in [AIS_CH_NUM];
	logic sel_offset;
	logic sel_divisor;
	logic sub_ch;
	logic ch_sel;
	logic acc;
	assign adc_in[0] = adc_raw_ch1;
	assign adc_in[1] = adc_raw_ch2;
	assign acc = od_wr | od_rd;
	assign sub_ch = (od_sub == AIS_SUB_CH1) || (od_sub == AIS_SUB_CH2);
	assign ch_sel = (od_sub == AIS_SUB_CH2);
	assign sel_offset = od_wr && od_index == AIS_IDX_OFFSET && sub_ch;
	assign sel_divisor = od_wr && od_index == AIS_IDX_DIVISOR && sub_ch && od_wdata != '0;

	// Divider state.
	ais_state_e state_q, state_d;
	logic ch_q, ch_d;
	logic [5:0] cnt_q, cnt_d;
	logic [32:0] quo_q, quo_d;
	logic [31:0] rem_q, rem_d;
	logic [31:0] den_q, den_d;
	logic neg_q, neg_d;
	logic signed [32:0] sum_q, sum_d;
	logic signed [31:0] dsr_q, dsr_d;
	logic [32:0] rem_sh;
	logic [32:0] rem_sub;
	logic ge;
	logic signed [32:0] res_s;
	logic [31:0] result;

	always_comb begin
		state_d = state_q;
		ch_d = ch_q;
		cnt_d = cnt_q;
		quo_d = quo_q;
		rem_d = rem_q;
		den_d = den_q;
		neg_d = neg_q;
		sum_d = sum_q;
		dsr_d = dsr_q;
		rem_sh = {rem_q, quo_q[32]};
		rem_sub = rem_sh - {1'b0, den_q};
		ge = rem_sh >= {1'b0, den_q};
		res_s = neg_q ? -$signed(quo_q) : $signed(quo_q);
		// The quotient of a large offset over divisor 1 can pass 32 bits; clamp, never wrap.
		if (res_s > AIS_POS_MAX) begin
			result = AIS_POS_MAX[31:0]; // R10
		end else if (res_s < AIS_NEG_MIN) begin
			result = AIS_NEG_MIN[31:0]; // R10
		end else begin
			result = res_s[31:0];
		end
		case (state_q)
			AIS_LOAD: begin
				// Sum in 33 bits so no offset can overflow it.
				sum_d = $signed({23'h000000, raw_q[ch_q]})
					+ $signed({offset_q[ch_q][31], offset_q[ch_q]}); // R1 R10
				dsr_d = $signed(divisor_q[ch_q]);
				quo_d = sum_d[32] ? 33'(-sum_d) : sum_d;
				den_d = divisor_q[ch_q][31] ? -divisor_q[ch_q] : divisor_q[ch_q];
				neg_d = sum_d[32] ^ divisor_q[ch_q][31]; // R10
				rem_d = '0;
				cnt_d = '0;
				state_d = AIS_DIV;
			end
			AIS_DIV: begin
				rem_d = ge ? rem_sub[31:0] : rem_sh[31:0];
				quo_d = {quo_q[31:0], ge}; // R1
				cnt_d = cnt_q + 6'h01;
				if (cnt_q == AIS_DIV_LAST) begin
					state_d = AIS_DONE;
				end
			end
			default: begin
				ch_d = ~ch_q; // R7
				state_d = AIS_LOAD;
			end
		endcase
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= AIS_LOAD;
			ch_q <= 1'b0;
			cnt_q <= '0;
			quo_q <= '0;
			rem_q <= '0;
			den_q <= AIS_DIVISOR_RST;
			neg_q <= 1'b0;
			sum_q <= '0;
			dsr_q <= $signed(AIS_DIVISOR_RST);
		end else begin
			state_q <= state_d;
			ch_q <= ch_d;
			cnt_q <= cnt_d;
			quo_q <= quo_d;
			rem_q <= rem_d;
			den_q <= den_d;
			neg_q <= neg_d;
			sum_q <= sum_d;
			dsr_q <= dsr_d;
		end
	end

	// Per-channel storage.
	for (genvar c = 0; c < AIS_CH_NUM; c++) begin : g_ch
		logic [AIS_RAW_W-1:0] raw_d;
		logic [31:0] offset_d;
		logic [31:0] divisor_d;
		logic [31:0] value_d;
		logic [31:0] phys_d;
		logic signed [11:0] zp;
		logic signed [22:0] prod;
		always_comb begin
			raw_d = adc_valid[c] ? adc_in[c] : raw_q[c];
			offset_d = (sel_offset && ch_sel == c) ? od_wdata : offset_q[c]; // R8
			divisor_d = (sel_divisor && ch_sel == c) ? od_wdata : divisor_q[c]; // R3 R9
			value_d = (state_q == AIS_DONE && ch_q == c) ? result : value_q[c]; // R7
			zp = ch_is_current[c] ? 12'sh000 : AIS_VOLT_ZERO; // R6
			prod = (23'($signed({2'b00, raw_q[c]})) - 23'(zp))
				* 23'($signed({1'b0, AIS_PHYS_MUL})); // R5 R6
			phys_d = 32'(prod >>> AIS_PHYS_SHIFT);
		end
		always_ff @(posedge mclk or posedge sys_rst) begin
			if (sys_rst) begin
				raw_q[c] <= '0;
				offset_q[c] <= AIS_OFFSET_RST;
				divisor_q[c] <= AIS_DIVISOR_RST;
				value_q[c] <= AIS_VALUE_RST;
				phys_q[c] <= '0;
			end else begin
				raw_q[c] <= raw_d;
				offset_q[c] <= offset_d;
				divisor_q[c] <= divisor_d;
				value_q[c] <= value_d;
				phys_q[c] <= phys_d;
			end
		end
	end

	assign pd_value_ch1 = value_q[0];
	assign pd_value_ch2 = value_q[1];
	assign phys_milli_ch1 = phys_q[0];
	assign phys_milli_ch2 = phys_q[1];
	assign pd_update = (state_q == AIS_DONE);

	// Access answer, one cycle after the strobe.
	logic [31:0] rdata_d;
	logic ack_d;
	logic err_d;
	always_comb begin
		rdata_d = '0;
		ack_d = acc;
		err_d = 1'b0;
		if (od_index == AIS_IDX_VALUE && od_sub == AIS_SUB_COUNT) begin
			rdata_d = {24'h000000, AIS_CH_COUNT}; // R2
			err_d = od_wr;
		end else if (od_index == AIS_IDX_VALUE && sub_ch) begin
			rdata_d = value_q[ch_sel];
			err_d = od_wr; // R7
		end else if (od_index == AIS_IDX_OFFSET && od_sub == AIS_SUB_COUNT) begin
			rdata_d = {24'h000000, AIS_CH_COUNT}; // R2
			err_d = od_wr;
		end else if (od_index == AIS_IDX_OFFSET && sub_ch) begin
			rdata_d = offset_q[ch_sel];
		end else if (od_index == AIS_IDX_DIVISOR && od_sub == AIS_SUB_COUNT) begin
			rdata_d = {24'h000000, AIS_CH_COUNT}; // R2
			err_d = od_wr;
		end else if (od_index == AIS_IDX_DIVISOR && sub_ch) begin
			rdata_d = divisor_q[ch_sel];
			err_d = od_wr && od_wdata == '0; // R3
		end else begin
			err_d = 1'b1;
		end
		if (!acc) begin
			rdata_d = '0;
			err_d = 1'b0;
		end
		if (od_wr) begin
			rdata_d = '0;
		end
	end
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			od_rdata <= '0;
			od_ack <= 1'b0;
			od_err <= 1'b0;
		end else begin
			od_rdata <= rdata_d;
			od_ack <= ack_d;
			od_err <= err_d;
		end
	end

	// Checks.
	divisor_nonzero_a: assert property (@(posedge mclk) disable iff (sys_rst) // R3
		divisor_q[0] != '0 && divisor_q[1] != '0)
		else $error("divisor holds zero");
	quotient_exact_a: assert property (@(posedge mclk) disable iff (sys_rst) // R1
		state_q == AIS_DONE && (sum_q / $signed({dsr_q[31], dsr_q})) <= AIS_POS_MAX
		&& (sum_q / $signed({dsr_q[31], dsr_q})) >= AIS_NEG_MIN
		|=> value_q[$past(ch_q)] == 32'(sum_q / $signed({dsr_q[31], dsr_q})))
		else $error("scaled value differs from truncated quotient");
	raw_identity_a: assert property (@(posedge mclk) disable iff (sys_rst) // R4
		state_q == AIS_LOAD && offset_q[ch_q] == '0 && divisor_q[ch_q] == 32'h00000001
		&& !adc_valid[ch_q] && !od_wr
		|-> ##35 value_q[$past(ch_q, 35)] == 32'($past(raw_q[ch_q], 35)))
		else $error("default scaling did not give raw counts");
	update_period_a: assert property (@(posedge mclk) disable iff (sys_rst) // R7
		$rose(state_q == AIS_DONE) |-> ##35 state_q == AIS_DONE)
		else $error("value update period wrong");
	value_readonly_a: assert property (@(posedge mclk) disable iff (sys_rst) // R7
		od_wr && od_index == AIS_IDX_VALUE |=> od_err && od_ack)
		else $error("write to value entry not refused");
	count_read_a: assert property (@(posedge mclk) disable iff (sys_rst) // R2
		od_rd && !od_wr && od_sub == AIS_SUB_COUNT && (od_index == AIS_IDX_VALUE
		|| od_index == AIS_IDX_OFFSET || od_index == AIS_IDX_DIVISOR)
		|=> od_rdata == 32'h00000002 && !od_err)
		else $error("channel count not reported");
	offset_write_a: assert property (@(posedge mclk) disable iff (sys_rst) // R8
		od_wr && od_index == AIS_IDX_OFFSET && od_sub == AIS_SUB_CH2
		|=> offset_q[1] == $past(od_wdata) && offset_q[0] == $past(offset_q[0]))
		else $error("offset write not independent");
	divisor_write_a: assert property (@(posedge mclk) disable iff (sys_rst) // R9
		od_wr && od_index == AIS_IDX_DIVISOR && od_sub == AIS_SUB_CH1 && od_wdata != '0
		|=> divisor_q[0] == $past(od_wdata) && divisor_q[1] == $past(divisor_q[1]))
		else $error("divisor write not stored");
	volt_scale_a: assert property (@(posedge mclk) disable iff (sys_rst) // R5
		!ch_is_current[0] |=> $signed(phys_q[0])
		== ($signed({22'h0, $past(raw_q[0])}) - 32'sd512) * 32'sd20000 >>> 10)
		else $error("voltage scaling wrong");
	curr_scale_a: assert property (@(posedge mclk) disable iff (sys_rst) // R6
		ch_is_current[1] |=> phys_q[1] == ({22'h0, $past(raw_q[1])} * 32'd20000) >> 10)
		else $error("current scaling wrong");
	update_c: cover property (@(posedge mclk) disable iff (sys_rst)
		state_q == AIS_DONE && neg_q);
	zero_div_c: cover property (@(posedge mclk) disable iff (sys_rst)
		od_wr && od_index == AIS_IDX_DIVISOR && sub_ch && od_wdata == '0);
	clamp_c: cover property (@(posedge mclk) disable iff (sys_rst)
		state_q == AIS_DONE && res_s > AIS_POS_MAX);
endmodule
`default_nettype wire

//--- dv/ais_adc_model.sv
// Converter model that hands both channels a fresh sample now and then.
`default_nettype none
module ais_adc_model #(
	parameter int GAP = 9
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic sys_rst,
	// Analog levels set by the bench.
	input wire logic [9:0] lvl_ch1,
	input wire logic [9:0] lvl_ch2,
	// Converter outputs.
	output logic [9:0] adc_raw_ch1,
	output logic [9:0] adc_raw_ch2,
	output logic [1:0] adc_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt;
	initial begin
		adc_raw_ch1 = 10'h000;
		adc_raw_ch2 = 10'h000;
		adc_valid = 2'h0;
		cnt = 0;
		forever begin
			@(negedge mclk);
			cnt = (sys_rst || cnt == GAP) ? 0 : cnt + 1;
			adc_valid = (cnt == GAP) ? 2'h3 : 2'h0;
			// Between samples the lines show the inverse, so a late latch reads wrong data.
			adc_raw_ch1 = (cnt == GAP) ? lvl_ch1 : ~lvl_ch1;
			adc_raw_ch2 = (cnt == GAP) ? lvl_ch2 : ~lvl_ch2;
		end
	end
endmodule
`default_nettype wire

//--- dv/analog_input_scaler_tb_top.sv
// Self-checking bench for the analog input scaler.
`default_nettype none
module analog_input_scaler_tb_top
	import ais_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk;
	logic sys_rst;
	logic [9:0] lvl_ch1;
	logic [9:0] lvl_ch2;
	logic [AIS_RAW_W-1:0] adc_raw_ch1;
	logic [AIS_RAW_W-1:0] adc_raw_ch2;
	logic [1:0] adc_valid;
	logic [1:0] ch_is_current;
	logic [15:0] od_index;
	logic [7:0] od_sub;
	logic od_wr;
	logic od_rd;
	logic [31:0] od_wdata;
	logic [31:0] od_rdata;
	logic od_ack;
	logic od_err;
	logic [31:0] pd_value_ch1;
	logic [31:0] pd_value_ch2;
	logic [31:0] phys_milli_ch1;
	logic [31:0] phys_milli_ch2;
	logic pd_update;
	logic [31:0] rd;
	int bad_count;
	int checks;
	int upd_n;
	ais_adc_model u_ais_adc_model (.mclk(mclk), .sys_rst(sys_rst), .lvl_ch1(lvl_ch1),
		.lvl_ch2(lvl_ch2), .adc_raw_ch1(adc_raw_ch1), .adc_raw_ch2(adc_raw_ch2),
		.adc_valid(adc_valid));
	ais_scaler u_ais_scaler (.mclk(mclk), .sys_rst(sys_rst), .adc_raw_ch1(adc_raw_ch1),
		.adc_raw_ch2(adc_raw_ch2), .adc_valid(adc_valid), .ch_is_current(ch_is_current),
		.od_index(od_index), .od_sub(od_sub), .od_wr(od_wr), .od_rd(od_rd),
		.od_wdata(od_wdata), .od_rdata(od_rdata), .od_ack(od_ack), .od_err(od_err),
		.pd_value_ch1(pd_value_ch1), .pd_value_ch2(pd_value_ch2),
		.phys_milli_ch1(phys_milli_ch1), .phys_milli_ch2(phys_milli_ch2),
		.pd_update(pd_update));
	task automatic test_done();
		if (bad_count == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One access: strobe for one cycle, answer checked at the next falling edge, half a cycle after the taking edge.
	task automatic acc(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
		input logic [31:0] wd, input logic err);
		@(negedge mclk);
		od_index = idx;
		od_sub = sub;
		od_wdata = wd;
		od_wr = wr;
		od_rd = !wr;
		@(negedge mclk);
		od_wr = 1'b0;
		od_rd = 1'b0;
		chk({31'h0, od_ack}, 32'h1);
		chk({31'h0, od_err}, {31'h0, err});
		rd = od_rdata;
	endtask
	task automatic rd_chk(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] e);
		acc(1'b0, idx, sub, 32'h0, 1'b0);
		chk(rd, e);
	endtask
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	// The whole sequence needs well under a thousand cycles.
	initial begin
		repeat (3000) @(posedge mclk);
		bad_count++;
		test_done();
	end
	initial begin
		sys_rst = 1'b1;
		lvl_ch1 = 10'd700;
		lvl_ch2 = 10'd100;
		ch_is_current = 2'b10;
		od_index = 16'h0000;
		od_sub = 8'h00;
		od_wr = 1'b0;
		od_rd = 1'b0;
		od_wdata = 32'h0;
		bad_count = 0;
		checks = 0;
		repeat (2) @(negedge mclk);
		sys_rst = 1'b0;
		rd_chk(AIS_IDX_VALUE, AIS_SUB_CH1, 32'h0);
		rd_chk(AIS_IDX_VALUE, AIS_SUB_COUNT, 32'h2);
		rd_chk(AIS_IDX_OFFSET, AIS_SUB_COUNT, 32'h2);
		rd_chk(AIS_IDX_DIVISOR, AIS_SUB_COUNT, 32'h2);
		rd_chk(AIS_IDX_OFFSET, AIS_SUB_CH2, 32'h0);
		rd_chk(AIS_IDX_DIVISOR, AIS_SUB_CH2, 32'h1);
		acc(1'b1, AIS_IDX_DIVISOR, AIS_SUB_COUNT, 32'h5, 1'b1);
		repeat (160) @(negedge mclk);
		chk(pd_value_ch1, 32'd700);
		chk(pd_value_ch2, 32'd100);
		rd_chk(AIS_IDX_VALUE, AIS_SUB_CH2, 32'd100);
		chk(phys_milli_ch1, 32'((700 - 512) * 20000 / 1024));
		chk(phys_milli_ch2, 32'(100 * 20000 / 1024));
		acc(1'b1, AIS_IDX_VALUE, AIS_SUB_CH1, 32'h5, 1'b1);
		acc(1'b1, AIS_IDX_OFFSET, AIS_SUB_CH1, 32'(-1000), 1'b0);
		chk(rd, 32'h0);
		acc(1'b1, AIS_IDX_DIVISOR, AIS_SUB_CH1, 32'h7, 1'b0);
		acc(1'b1, AIS_IDX_OFFSET, AIS_SUB_CH2, 32'h7FFFFFFF, 1'b0);
		acc(1'b1, AIS_IDX_DIVISOR, AIS_SUB_CH2, 32'(-2), 1'b0);
		acc(1'b1, AIS_IDX_DIVISOR, AIS_SUB_CH1, 32'h0, 1'b1);
		acc(1'b0, 16'h3323, AIS_SUB_CH1, 32'h0, 1'b1);
		chk(rd, 32'h0);
		rd_chk(AIS_IDX_DIVISOR, AIS_SUB_CH1, 32'h7);
		rd_chk(AIS_IDX_OFFSET, AIS_SUB_CH1, 32'(-1000));
		lvl_ch1 = 10'd100;
		repeat (160) @(negedge mclk);
		chk(pd_value_ch1, 32'((100 - 1000) / 7));
		chk(pd_value_ch2, 32'((64'sd2147483647 + 64'sd100) / -64'sd2));
		rd_chk(AIS_IDX_VALUE, AIS_SUB_CH1, 32'(-128));
		// Negative voltage readings floor after the shift.
		chk(phys_milli_ch1, 32'(-8047));
		// A divisor of one over the largest offset overshoots 32 bits and must clamp.
		acc(1'b1, AIS_IDX_DIVISOR, AIS_SUB_CH2, 32'h1, 1'b0);
		repeat (160) @(negedge mclk);
		chk(pd_value_ch2, 32'h7FFFFFFF);
		// Each channel finishes once every 70 cycles, so 140 cycles hold four updates.
		upd_n = 0;
		repeat (140) begin
			@(negedge mclk);
			if (pd_update) begin
				upd_n++;
			end
		end
		chk(upd_n, 32'd4);
		test_done();
	end
endmodule
`default_nettype wire
